// *** src/port_ctl_pkg.sv ***
package port_ctl_pkg;

  // Port and store geometry
  localparam int         OUT_W       = 8;
  localparam int         LOWER_CH    = 4;
  localparam int         NV_BYTES    = 6;
  localparam logic [7:0] PTR_NV_END  = 8'h06;
  localparam logic [7:0] PTR_VOL_BASE = 8'h06;
  localparam logic [7:0] PTR_LIMIT   = 8'h0C;
  localparam logic [2:0] IDX_OUT     = 3'h0;
  localparam logic [2:0] IDX_DELAY0  = 3'h1;
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [7:0] ELAPSED_MAX = 8'hFF;

  // Serial target address, arbitrary value
  localparam logic [6:0] TARGET_ADDR = 7'h3A;

  // Timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int SCL_MAX_HZ    = 400_000;
  localparam int SCL_HALF_CYC  = CLK_HZ / (2 * SCL_MAX_HZ);
  localparam int SYNC_LATENCY  = 3;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYCLES_DEFAULT = (CLK_HZ / 1_000_000) * TICK_US;

  // Synchroniser bit positions
  localparam int SY_SCL   = 0;
  localparam int SY_SDA   = 1;
  localparam int SY_WP    = 2;
  localparam int SY_PD    = 3;
  localparam int SY_TIMER_ENABLE_IN = 4;
  localparam int SY_RSTN  = 5;
  localparam int SY_W     = 6;

  // Register map (byte addresses)
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] OFS_OUT    = 8'h00;
  localparam logic [7:0] OFS_DELAY  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_NVCTL  = 8'h0C;
  localparam int NV_COMMIT_BIT  = 0;
  localparam int NV_RELOAD_BIT  = 1;
  localparam int NV_REFUSED_BIT = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Serial target states
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK_A = 9'h004,
    ST_PTR   = 9'h008,
    ST_ACK_P = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_W = 9'h040,
    ST_RDATA = 9'h080,
    ST_ACK_R = 9'h100
  } i2c_state_t;

endpackage : port_ctl_pkg

// *** src/programmable_port_controller.sv ***
module programmable_port_controller #(
  parameter bit PIN_IS_RESET = 1'b0,
  parameter bit EXT_CLOCK    = 1'b0,
  parameter bit PULLDOWN_PIN = 1'b1,
  parameter int TICK_CYCLES  = port_ctl_pkg::TICK_CYCLES_DEFAULT
) (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // Register bus, write
  input  wire logic [port_ctl_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // Register bus, read
  input  wire logic [port_ctl_pkg::ADDR_W-1:0] araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // Serial bus pins
  input  wire logic                          scl_i,
  output logic                               scl_o,
  output logic                               scl_oe,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_oe,
  // Control pins
  input  wire logic                          write_protect,
  input  wire logic                          timer_enable_in,
  input  wire logic                          reset_n_in,
  input  wire logic                          bus_pulldown_n,
  // Output ports
  output logic                               timed_out_0,
  output logic                               timed_out_1,
  output logic                               timed_out_2,
  output logic                               timed_out_3,
  output logic                               fixed_out_4,
  output logic                               fixed_out_5,
  output logic                               fixed_out_6,
  output logic                               fixed_out_7
);

  typedef struct packed {
    logic [port_ctl_pkg::SY_W-1:0] s1;
    logic [port_ctl_pkg::SY_W-1:0] s2;
    logic                        scl_d;
    logic                        sda_d;
    port_ctl_pkg::i2c_state_t    st;
    logic [2:0]                  bitcnt;
    logic                        byte_done;
    logic                        rw;
    logic                        nack;
    logic [7:0]                  shreg;
    logic [7:0]                  ptr;
    logic                        sda_drv;
    logic [5:0][7:0]             nvm;
    logic [5:0][7:0]             vol;
    logic                        timer_enable_in_d;
    logic                        running;
    logic [31:0]                 prescale;
    logic [7:0]                  elapsed;
    logic [3:0]                  inv;
    logic [7:0]                  pins;
    logic                        reload_pend;
    logic                        refused;
    logic                        aw_have;
    logic                        w_have;
    logic [7:0]                  aw_q;
    logic [31:0]                 w_q;
    logic [3:0]                  strb_q;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
  } state_t;

  state_t     r_reg;
  state_t     r_next;
  logic       scl_s;
  logic       sda_s;
  logic       rise;
  logic       fall;
  logic       start_c;
  logic       stop_c;
  logic       wp_s;
  logic       timer_enable_in_eff;
  logic       hold;
  logic       pd_act;
  logic [7:0] rd_byte;
  logic [7:0] rd_next;
  logic [7:0] ptr_inc;

  // Store and register byte seen by the serial bus at a pointer
  function automatic logic [7:0] peek(
    input logic [7:0]      p,
    input logic [5:0][7:0] nvm,
    input logic [5:0][7:0] vol
  );
    logic [7:0] v;
    v = 8'h00;
    if (p < port_ctl_pkg::PTR_NV_END)
      v = nvm[p[2:0]];
    else if (p < port_ctl_pkg::PTR_LIMIT)
      v = vol[3'(p - port_ctl_pkg::PTR_VOL_BASE)];
    return v;
  endfunction : peek

  // Edge and condition detection on synchronised bus lines
  assign scl_s   = r_reg.s2[port_ctl_pkg::SY_SCL];
  assign sda_s   = r_reg.s2[port_ctl_pkg::SY_SDA];
  assign rise    = scl_s & ~r_reg.scl_d;
  assign fall    = ~scl_s & r_reg.scl_d;
  assign start_c = scl_s & r_reg.scl_d & r_reg.sda_d & ~sda_s;
  assign stop_c  = scl_s & r_reg.scl_d & ~r_reg.sda_d & sda_s;
  assign wp_s    = r_reg.s2[port_ctl_pkg::SY_WP];

  // Shared pin options: one function each, never both
  assign timer_enable_in_eff = PIN_IS_RESET ? 1'b0 : r_reg.s2[port_ctl_pkg::SY_TIMER_ENABLE_IN];
  assign hold      = PIN_IS_RESET & ~r_reg.s2[port_ctl_pkg::SY_RSTN];
  // External clock takes the pin over, so no pull-down then
  assign pd_act    = PULLDOWN_PIN & ~EXT_CLOCK
                     & ~r_reg.s2[port_ctl_pkg::SY_PD];

  assign rd_byte = peek(r_reg.ptr, r_reg.nvm, r_reg.vol);
  assign ptr_inc = r_reg.ptr + 8'h01;
  assign rd_next = peek(ptr_inc, r_reg.nvm, r_reg.vol);

  always_comb
  begin
    r_next = r_reg;

    // Two-stage synchronisers for every pin input
    r_next.s1[port_ctl_pkg::SY_SCL]   = scl_i;
    r_next.s1[port_ctl_pkg::SY_SDA]   = sda_i;
    r_next.s1[port_ctl_pkg::SY_WP]    = write_protect;
    r_next.s1[port_ctl_pkg::SY_PD]    = bus_pulldown_n;
    r_next.s1[port_ctl_pkg::SY_TIMER_ENABLE_IN] = timer_enable_in;
    r_next.s1[port_ctl_pkg::SY_RSTN]  = reset_n_in;
    r_next.s2    = r_reg.s1;
    r_next.scl_d = scl_s;
    r_next.sda_d = sda_s;

    // Reload volatile copy once reset has let go
    if (r_reg.reload_pend && !hold)
    begin
      r_next.vol         = r_reg.nvm;
      r_next.reload_pend = 1'b0;
    end

    // Serial target: sample on rising, change data on falling
    if (start_c)
    begin
      r_next.st        = port_ctl_pkg::ST_ADDR;
      r_next.bitcnt    = 3'h0;
      r_next.byte_done = 1'b0;
      r_next.sda_drv   = 1'b0;
    end
    else if (stop_c)
    begin
      r_next.st      = port_ctl_pkg::ST_IDLE;
      r_next.sda_drv = 1'b0;
    end
    else if (rise)
    begin
      case (r_reg.st)
        port_ctl_pkg::ST_ADDR, port_ctl_pkg::ST_PTR, port_ctl_pkg::ST_WDATA:
        begin
          r_next.shreg     = {r_reg.shreg[6:0], sda_s};
          r_next.bitcnt    = r_reg.bitcnt + 3'h1;
          r_next.byte_done = (r_reg.bitcnt == port_ctl_pkg::BIT_LAST);
        end
        port_ctl_pkg::ST_RDATA:
        begin
          r_next.bitcnt    = r_reg.bitcnt + 3'h1;
          r_next.byte_done = (r_reg.bitcnt == port_ctl_pkg::BIT_LAST);
        end
        port_ctl_pkg::ST_ACK_R:
          r_next.nack = sda_s;
        default:
          r_next.st = r_reg.st;
      endcase
    end
    else if (fall)
    begin
      case (r_reg.st)
        port_ctl_pkg::ST_ADDR:
        begin
          if (r_reg.byte_done)
          begin
            r_next.byte_done = 1'b0;
            // Only answer our own address; others are left alone
            if (r_reg.shreg[7:1] == port_ctl_pkg::TARGET_ADDR)
            begin
              r_next.rw      = r_reg.shreg[0];
              r_next.sda_drv = 1'b1;
              r_next.st      = port_ctl_pkg::ST_ACK_A;
            end
            else
              r_next.st = port_ctl_pkg::ST_IDLE;
          end
        end
        port_ctl_pkg::ST_PTR:
        begin
          if (r_reg.byte_done)
          begin
            r_next.byte_done = 1'b0;
            r_next.ptr       = r_reg.shreg;
            r_next.sda_drv   = 1'b1;
            r_next.st        = port_ctl_pkg::ST_ACK_P;
          end
        end
        port_ctl_pkg::ST_WDATA:
        begin
          if (r_reg.byte_done)
          begin
            r_next.byte_done = 1'b0;
            if (r_reg.ptr < port_ctl_pkg::PTR_NV_END)
            begin
              if (!wp_s)
                r_next.nvm[r_reg.ptr[2:0]] = r_reg.shreg;
              r_next.refused = wp_s;
            end
            else if (r_reg.ptr < port_ctl_pkg::PTR_LIMIT)
              r_next.vol[3'(r_reg.ptr - port_ctl_pkg::PTR_VOL_BASE)] = r_reg.shreg;
            // Refused bytes are still acknowledged, as a store would
            r_next.ptr     = ptr_inc;
            r_next.sda_drv = 1'b1;
            r_next.st      = port_ctl_pkg::ST_ACK_W;
          end
        end
        port_ctl_pkg::ST_ACK_A:
        begin
          if (r_reg.rw)
          begin
            r_next.shreg   = rd_byte;
            r_next.sda_drv = ~rd_byte[7];
            r_next.st      = port_ctl_pkg::ST_RDATA;
          end
          else
          begin
            r_next.sda_drv = 1'b0;
            r_next.st      = port_ctl_pkg::ST_PTR;
          end
        end
        port_ctl_pkg::ST_ACK_P, port_ctl_pkg::ST_ACK_W:
        begin
          r_next.sda_drv = 1'b0;
          r_next.st      = port_ctl_pkg::ST_WDATA;
        end
        port_ctl_pkg::ST_RDATA:
        begin
          if (r_reg.byte_done)
          begin
            r_next.byte_done = 1'b0;
            r_next.sda_drv   = 1'b0;
            r_next.st        = port_ctl_pkg::ST_ACK_R;
          end
          else
          begin
            r_next.shreg   = {r_reg.shreg[6:0], 1'b0};
            r_next.sda_drv = ~r_reg.shreg[6];
          end
        end
        port_ctl_pkg::ST_ACK_R:
        begin
          if (!r_reg.nack)
          begin
            r_next.ptr     = ptr_inc;
            r_next.shreg   = rd_next;
            r_next.sda_drv = ~rd_next[7];
            r_next.st      = port_ctl_pkg::ST_RDATA;
          end
          else
            r_next.st = port_ctl_pkg::ST_IDLE;
        end
        default:
          r_next.st = r_reg.st;
      endcase
    end

    // Timer: enable gates it, its rising edge restarts it
    r_next.timer_enable_in_d = timer_enable_in_eff;
    if (!timer_enable_in_eff)
    begin
      r_next.running  = 1'b0;
      r_next.prescale = 32'h0;
      r_next.elapsed  = 8'h00;
      r_next.inv      = 4'h0;
    end
    else if (!r_reg.timer_enable_in_d)
    begin
      r_next.running  = 1'b1;
      r_next.prescale = 32'h0;
      r_next.elapsed  = 8'h00;
      r_next.inv      = 4'h0;
    end
    else if (r_reg.running)
    begin
      if (r_reg.prescale == 32'(TICK_CYCLES - 1))
      begin
        r_next.prescale = 32'h0;
        // Saturate so a long wait never wraps back
        if (r_reg.elapsed != port_ctl_pkg::ELAPSED_MAX)
          r_next.elapsed = r_reg.elapsed + 8'h01;
      end
      else
        r_next.prescale = r_reg.prescale + 32'h1;
      for (int i = 0; i < port_ctl_pkg::LOWER_CH; i++)
        if (r_reg.elapsed >= r_reg.vol[port_ctl_pkg::IDX_DELAY0 + 3'(i)])
          r_next.inv[i] = 1'b1;
    end

    // Register bus: address and data taken in either order
    if (awvalid && awready)
    begin
      r_next.aw_have = 1'b1;
      r_next.aw_q    = awaddr;
    end
    if (wvalid && wready)
    begin
      r_next.w_have = 1'b1;
      r_next.w_q    = wdata;
      r_next.strb_q = wstrb;
    end
    if (r_reg.bvalid && bready)
      r_next.bvalid = 1'b0;
    if (r_reg.aw_have && r_reg.w_have)
    begin
      r_next.aw_have = 1'b0;
      r_next.w_have  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = port_ctl_pkg::RESP_OKAY;
      case (r_reg.aw_q)
        port_ctl_pkg::OFS_OUT:
          if (r_reg.strb_q[0])
            r_next.vol[port_ctl_pkg::IDX_OUT] = r_reg.w_q[7:0];
        port_ctl_pkg::OFS_DELAY:
          for (int i = 0; i < port_ctl_pkg::LOWER_CH; i++)
            if (r_reg.strb_q[i])
              r_next.vol[port_ctl_pkg::IDX_DELAY0 + 3'(i)] = r_reg.w_q[8*i +: 8];
        port_ctl_pkg::OFS_STATUS:
          r_next.bresp = port_ctl_pkg::RESP_OKAY;
        port_ctl_pkg::OFS_NVCTL:
        begin
          if (r_reg.strb_q[0] && r_reg.w_q[port_ctl_pkg::NV_COMMIT_BIT])
          begin
            if (!wp_s)
              r_next.nvm = r_reg.vol;
            r_next.refused = wp_s;
          end
          if (r_reg.strb_q[0] && r_reg.w_q[port_ctl_pkg::NV_RELOAD_BIT])
            r_next.vol = r_reg.nvm;
        end
        default:
          r_next.bresp = port_ctl_pkg::RESP_SLVERR;
      endcase
    end
    if (r_reg.rvalid && rready)
      r_next.rvalid = 1'b0;
    if (arvalid && arready)
    begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = port_ctl_pkg::RESP_OKAY;
      r_next.rdata  = 32'h0;
      case (araddr)
        port_ctl_pkg::OFS_OUT:
          r_next.rdata[7:0] = r_reg.vol[port_ctl_pkg::IDX_OUT];
        port_ctl_pkg::OFS_DELAY:
          r_next.rdata = r_reg.vol[4:1];
        port_ctl_pkg::OFS_STATUS:
          r_next.rdata[11:0] = {hold, pd_act, wp_s, r_reg.running, r_reg.pins};
        port_ctl_pkg::OFS_NVCTL:
          r_next.rdata[port_ctl_pkg::NV_REFUSED_BIT] = r_reg.refused;
        default:
          r_next.rresp = port_ctl_pkg::RESP_SLVERR;
      endcase
    end

    // Reset pin low keeps the core initialised; store is kept
    if (hold)
    begin
      r_next.st          = port_ctl_pkg::ST_IDLE;
      r_next.sda_drv     = 1'b0;
      r_next.running     = 1'b0;
      r_next.prescale    = 32'h0;
      r_next.elapsed     = 8'h00;
      r_next.inv         = 4'h0;
      r_next.reload_pend = 1'b1;
    end

    // Lower channels may invert, upper ones never do
    r_next.pins = r_next.vol[port_ctl_pkg::IDX_OUT]
                  ^ {4'h0, r_next.inv};

    // Synchronous reset: idle bus, lines seen high, reload armed
    if (!aresetn)
    begin
      r_next             = '0;
      r_next.s1          = '1;
      r_next.s2          = '1;
      r_next.scl_d       = 1'b1;
      r_next.sda_d       = 1'b1;
      r_next.timer_enable_in_d     = 1'b1;
      r_next.st          = port_ctl_pkg::ST_IDLE;
      r_next.reload_pend = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge aclk)
  begin
    r_reg <= r_next;
  end

  // Bus handshakes, one transfer of each kind at a time
  assign awready = ~r_reg.aw_have & ~r_reg.bvalid;
  assign wready  = ~r_reg.w_have & ~r_reg.bvalid;
  assign bvalid  = r_reg.bvalid;
  assign bresp   = r_reg.bresp;
  assign arready = ~r_reg.rvalid;
  assign rvalid  = r_reg.rvalid;
  assign rdata   = r_reg.rdata;
  assign rresp   = r_reg.rresp;

  // Open-drain lines: only ever pulled low
  assign sda_o  = 1'b0;
  assign sda_oe = r_reg.sda_drv | pd_act;
  assign scl_o  = 1'b0;
  assign scl_oe = pd_act;

  // Output ports straight from the pin register
  assign timed_out_0 = r_reg.pins[0];
  assign timed_out_1 = r_reg.pins[1];
  assign timed_out_2 = r_reg.pins[2];
  assign timed_out_3 = r_reg.pins[3];
  assign fixed_out_4 = r_reg.pins[4];
  assign fixed_out_5 = r_reg.pins[5];
  assign fixed_out_6 = r_reg.pins[6];
  assign fixed_out_7 = r_reg.pins[7];

endmodule : programmable_port_controller

// *** tb/port_ctl_sva.sv ***
module port_ctl_sva (
  // Clock and reset
  input wire logic                            aclk,
  input wire logic                            aresetn,
  // Register bus
  input wire logic                            awvalid,
  input wire logic                            awready,
  input wire logic                            wvalid,
  input wire logic                            wready,
  input wire logic [1:0]                      bresp,
  input wire logic                            bvalid,
  input wire logic                            bready,
  input wire logic [port_ctl_pkg::ADDR_W-1:0] araddr,
  input wire logic                            arvalid,
  input wire logic                            arready,
  input wire logic [1:0]                      rresp,
  input wire logic                            rvalid,
  input wire logic                            rready,
  // Serial pins and pull-down
  input wire logic                            scl_i,
  input wire logic                            scl_o,
  input wire logic                            scl_oe,
  input wire logic                            sda_o,
  input wire logic                            sda_oe,
  input wire logic                            bus_pulldown_n,
  // Upper outputs
  input wire logic                            fixed_out_4,
  input wire logic                            fixed_out_5,
  input wire logic                            fixed_out_6,
  input wire logic                            fixed_out_7
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Named steps; the five-cycle holds cover the pin synchroniser
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence pd_held;
    !bus_pulldown_n [*5];
  endsequence
  sequence pd_off;
    bus_pulldown_n [*5];
  endsequence
  sequence bus_quiet;
    (!awvalid && scl_i) [*8];
  endsequence

  chk_sda_open_drain: assert property (!sda_o)
    else $error("data pin driven high");
  chk_scl_open_drain: assert property (!scl_o && scl_oe == !$past(bus_pulldown_n, 2))
    else $error("clock pin driven high or pull-down not followed");
  chk_pulldown_force: assert property (pd_held |-> scl_oe && sda_oe)
    else $error("pull-down did not hold both lines");
  chk_pulldown_release: assert property (pd_off |-> !scl_oe)
    else $error("clock line held without pull-down");
  chk_upper_fixed: assert property (bus_quiet |-> $stable({fixed_out_7, fixed_out_6,
    fixed_out_5, fixed_out_4}))
    else $error("upper output moved without a write");
  chk_write_answer: assert property (wr_taken |-> ##[1:3] bvalid)
    else $error("write not answered");
  chk_wresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_unmapped_read: assert property (arvalid && arready && araddr > 8'h0C
    |=> rvalid && rresp == port_ctl_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
  chk_rresp_hold: assert property (rvalid && !rready |=> rvalid && $stable(rresp))
    else $error("read response dropped early");
endmodule : port_ctl_sva

// *** tb/i2c_host_model.sv ***
module i2c_host_model (
  // Data line as seen on the wire
  input  wire logic sda,
  // Pull-low requests, open drain
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus: clock stands high, both lines released
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // Data falls while clock high
  task automatic start_cond();
    #20 sda_low = 1'b1;
    #20 scl_low = 1'b1;
  endtask : start_cond

  // Data rises while clock high
  task automatic stop_cond();
    #20 sda_low = 1'b1;
    #20 scl_low = 1'b0;
    #20 sda_low = 1'b0;
    #20;
  endtask : stop_cond

  // Nine bits MSB first at 80 ns; a 1 releases the line for the target
  task automatic frame9(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      #20 sda_low = !d[i];
      #20 scl_low = 1'b0;
      #20 q[i] = sda;  // Mid-high, after the target's edge handling
      #20 scl_low = 1'b1;
    end
  endtask : frame9
endmodule : i2c_host_model

// *** tb/programmable_port_controller_tb.sv ***
module programmable_port_controller_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // Design inputs, valued from time zero; ready lines start high
  logic        aclk = 1'b0, aresetn = 1'b0, bready = 1'b1, rready = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        write_protect = 1'b0, timer_enable_in = 1'b0, bus_pulldown_n = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, scl_low, sda_low;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [31:0] seed = 32'h97CD;
  logic [7:0]  pins;
  logic [8:0]  q;
  int          failures = 0;
  int          tests_run = 0;
  localparam logic [6:0] TGT = port_ctl_pkg::TARGET_ADDR;
  localparam logic [8:0] PTR = {port_ctl_pkg::PTR_VOL_BASE, 1'b1};
  localparam logic [31:0] DLY = 32'hFF28_0200;

  // Board pull-ups: a line is low while anyone pulls it
  assign scl_i = !(scl_low | scl_oe);
  assign sda_i = !(sda_low | sda_oe);

  programmable_port_controller #(.TICK_CYCLES(10)) u_programmable_port_controller (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .write_protect(write_protect), .timer_enable_in(timer_enable_in),
    .reset_n_in(1'b1), .bus_pulldown_n(bus_pulldown_n), .timed_out_0(pins[0]),
    .timed_out_1(pins[1]), .timed_out_2(pins[2]), .timed_out_3(pins[3]),
    .fixed_out_4(pins[4]), .fixed_out_5(pins[5]), .fixed_out_6(pins[6]),
    .fixed_out_7(pins[7]));

  i2c_host_model u_i2c_host_model (.sda(sda_i), .scl_low(scl_low), .sda_low(sda_low));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Lower half inverts once elapsed ticks reach its delay
  function automatic logic [7:0] exp_pins(input logic [7:0] o, input int t);
    logic [7:0] v;
    v = o;
    for (int i = 0; i < 4; i++)
      if (DLY[8*i +: 8] <= t) v[i] = !v[i];
    return v;
  endfunction : exp_pins

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Handshakes judged at the negedge, acted on at the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb, tv;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !v[0];  // Response ready sometimes late
    forever
    begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      tv = bvalid;
      if (tb) check(32'(bresp), 32'(port_ctl_pkg::RESP_OKAY));
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
      if (tv) bready <= 1'b1;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    logic ta, tr, tv;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= a[2];  // Read ready sometimes late
    forever
    begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid & rready;
      tv = rvalid;
      v = rdata;
      e = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) break;
      if (tv) rready <= 1'b1;
    end
  endtask : axi_rd

  task automatic results();
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  initial
  begin
    forever #5 aclk = !aclk;
  end

  // Expected run is near 1,000 cycles
  initial
  begin
    #100000;
    failures++;
    results();
  end

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check(32'(pins), 32'h0);
    repeat (4)
    begin
      seed = lfsr(seed);
      axi_wr(port_ctl_pkg::OFS_OUT, seed);
      axi_rd(port_ctl_pkg::OFS_OUT, d, r);
      check(d & 32'hFF, seed & 32'hFF);
      check(32'(pins), seed & 32'hFF);
    end
    axi_rd(8'h10, d, r);
    check(32'(r), 32'(port_ctl_pkg::RESP_SLVERR));
    // Protect refuses the commit but never the volatile write
    write_protect <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_wr(port_ctl_pkg::OFS_OUT, 32'h5A);
    axi_wr(port_ctl_pkg::OFS_NVCTL, 32'h1);
    axi_rd(port_ctl_pkg::OFS_NVCTL, d, r);
    check(32'(d[2]), 32'h1);
    check(32'(pins), 32'h5A);
    write_protect <= 1'b0;
    repeat (4) @(posedge aclk);
    axi_wr(port_ctl_pkg::OFS_NVCTL, 32'h1);
    axi_rd(port_ctl_pkg::OFS_NVCTL, d, r);
    check(32'(d[2]), 32'h0);
    axi_wr(port_ctl_pkg::OFS_OUT, 32'hC3);
    axi_wr(port_ctl_pkg::OFS_NVCTL, 32'h2);
    repeat (4) @(posedge aclk);
    check(32'(pins), 32'h5A);
    // Serial write of a random level byte, read back, foreign address
    seed = lfsr(seed);
    #3;
    u_i2c_host_model.start_cond();
    u_i2c_host_model.frame9({TGT, 2'b01}, q);
    check(32'(q[0]), 32'h0);
    u_i2c_host_model.frame9(PTR, q);
    u_i2c_host_model.frame9({seed[7:0], 1'b1}, q);
    u_i2c_host_model.stop_cond();
    check(32'(pins), seed & 32'hFF);
    u_i2c_host_model.start_cond();
    u_i2c_host_model.frame9({TGT, 2'b01}, q);
    u_i2c_host_model.frame9(PTR, q);
    u_i2c_host_model.stop_cond();
    u_i2c_host_model.start_cond();
    u_i2c_host_model.frame9({TGT, 2'b11}, q);
    u_i2c_host_model.frame9(9'h1FF, q);
    u_i2c_host_model.stop_cond();
    check(32'(q[8:1]), seed & 32'hFF);
    u_i2c_host_model.start_cond();
    u_i2c_host_model.frame9({TGT ^ 7'h01, 2'b01}, q);
    u_i2c_host_model.stop_cond();
    check(32'(q[0]), 32'h1);
    // Timer run of some 24 ticks: delays 0 and 2 pass, 40 and 255 not
    @(posedge aclk);
    axi_wr(port_ctl_pkg::OFS_OUT, 32'hA5);
    axi_wr(port_ctl_pkg::OFS_DELAY, DLY);
    axi_rd(port_ctl_pkg::OFS_DELAY, d, r);
    check(d, DLY);
    timer_enable_in <= 1'b1;
    repeat (250) @(posedge aclk);
    check(32'(pins), 32'(exp_pins(8'hA5, 25)));
    timer_enable_in <= 1'b0;
    repeat (8) @(posedge aclk);
    check(32'(pins), 32'hA5);
    bus_pulldown_n <= 1'b0;
    repeat (6) @(posedge aclk);
    check(32'({scl_i, sda_i}), 32'h0);
    bus_pulldown_n <= 1'b1;
    repeat (6) @(posedge aclk);
    check(32'({scl_i, sda_i}), 32'h3);
    results();
  end
endmodule : programmable_port_controller_tb

bind programmable_port_controller port_ctl_sva u_port_ctl_sva (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rresp(rresp), .rvalid(rvalid), .rready(rready), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .bus_pulldown_n(bus_pulldown_n),
  .fixed_out_4(fixed_out_4), .fixed_out_5(fixed_out_5), .fixed_out_6(fixed_out_6),
  .fixed_out_7(fixed_out_7));
